/* File: pin_sync.sv */
`timescale 1ns/1ps
module pin_sync (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   // asynchronous pins
   input  wire logic [1:0] i_d,
   // synchronised levels
   output logic      [1:0] o_q
);

   logic [1:0] meta_reg;
   logic [1:0] q_reg;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_bit
         always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               meta_reg[g] <= 1'b0;
               q_reg[g]    <= 1'b0;
            end else begin
               meta_reg[g] <= i_d[g];
               q_reg[g]    <= meta_reg[g];
            end
         end
      end
   endgenerate

   assign o_q = q_reg;

endmodule : pin_sync

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
   localparam int EXP = 20;
   localparam logic [31:0] WADDR = 32'h0A000001;
   logic        i_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic        i_acq_start;
   logic        i_net_addr_restore_in = 1'b0;
   logic        i_slave_mode = 1'b1;
   logic        i_trig_falling = 1'b0;
   logic        i_exp_pol_high = 1'b0;
   logic [23:0] i_exposure_len = 24'h14;
   logic        i_variant_usb = 1'b1;
   logic        i_usb_enumerated = 1'b0;
   logic        i_eth_connected = 1'b0;
   logic        i_fw_upgrade = 1'b0;
   logic        i_drv_upgrade = 1'b0;
   logic        i_net_addr_wr = 1'b0;
   logic [31:0] i_net_addr_wdata = 32'h0;
   logic        o_acq_start, o_exposing, o_exposure_window;
   logic [31:0] o_net_addr;
   logic        o_addr_restore, o_self_reset, o_usb_device_mode;
   logic        o_led_red, o_led_green, o_led_blue;
   logic [2:0]  led;
   int          num_errors = 0;
   int          n_tests = 0;
   int          acq_cnt = 0, exp_cnt = 0, win_cnt = 0, rst_cnt = 0;
   int          self_cnt = 0, pur_cnt = 0, pur_rise = 0;
   bit          pur_prev = 1'b0;

   assign led = {o_led_red, o_led_green, o_led_blue};

   initial begin
      forever #10 i_clk = ~i_clk;
   end

   trig_source trig_source_i (
      .i_clk  (i_clk),
      .o_trig (i_acq_start)
   );

   trigger_exposure_status_logic #(
      .ADDR_HOLD_CYCLES   (200),
      .PURPLE_HOLD_CYCLES (100),
      .PURPLE_SHOW_CYCLES (100),
      .BLINK_HALF_CYCLES  (10)
   ) trigger_exposure_status_logic_i (
      .i_clk                 (i_clk),
      .i_resetn              (i_resetn),
      .i_acq_start           (i_acq_start),
      .i_net_addr_restore_in (i_net_addr_restore_in),
      .i_slave_mode          (i_slave_mode),
      .i_trig_falling        (i_trig_falling),
      .i_exp_pol_high        (i_exp_pol_high),
      .i_exposure_len        (i_exposure_len),
      .i_variant_usb         (i_variant_usb),
      .i_usb_enumerated      (i_usb_enumerated),
      .i_eth_connected       (i_eth_connected),
      .i_fw_upgrade          (i_fw_upgrade),
      .i_drv_upgrade         (i_drv_upgrade),
      .i_net_addr_wr         (i_net_addr_wr),
      .i_net_addr_wdata      (i_net_addr_wdata),
      .o_acq_start           (o_acq_start),
      .o_exposing            (o_exposing),
      .o_exposure_window     (o_exposure_window),
      .o_net_addr            (o_net_addr),
      .o_addr_restore        (o_addr_restore),
      .o_self_reset          (o_self_reset),
      .o_usb_device_mode     (o_usb_device_mode),
      .o_led_red             (o_led_red),
      .o_led_green           (o_led_green),
      .o_led_blue            (o_led_blue)
   );

   always @(posedge i_clk) begin
      if (o_acq_start === 1'b1) acq_cnt++;
      if (o_exposing === 1'b1) exp_cnt++;
      if (o_exposure_window === i_exp_pol_high) win_cnt++;
      if (o_addr_restore === 1'b1) rst_cnt++;
      if (o_self_reset === 1'b1) self_cnt++;
      if (led === trig_status_pkg::LED_PURPLE) pur_cnt++;
      if (led === trig_status_pkg::LED_PURPLE && !pur_prev) pur_rise++;
      pur_prev = (led === trig_status_pkg::LED_PURPLE);
   end

   task automatic conclude;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h",
                  $time, m, got, exp);
      end
   endtask : chk

   // counters cleared only after the new polarity has settled on the pin
   task automatic trig_run(input logic slv, input logic fal,
                           input logic pol, input int mid, input int fin);
      int a0;
      i_slave_mode = slv;
      i_trig_falling = fal;
      i_exp_pol_high = pol;
      repeat (5) @(negedge i_clk);
      a0 = acq_cnt;
      exp_cnt = 0;
      win_cnt = 0;
      fork
         trig_source_i.pulse(5000);
         begin
            repeat (40) @(negedge i_clk);
            chk(32'(acq_cnt - a0), 32'(mid), "start before fall");
         end
      join
      repeat (40) @(negedge i_clk);
      chk(32'(acq_cnt - a0), 32'(fin), "starts per pulse");
      chk(32'(exp_cnt), 32'(fin * EXP), "exposing length");
      chk(32'(win_cnt), 32'(fin * EXP), "window active length");
   endtask : trig_run

   task automatic led_chk(input logic [2:0] col, input bit blink,
                          input string m);
      int on, off;
      on = 0;
      off = 0;
      repeat (3) @(negedge i_clk);
      repeat (40) begin
         @(negedge i_clk);
         if (led === col) on++;
         else if (led === 3'h0) off++;
      end
      chk(32'(on + off), 32'h28, m);
      chk(32'(on), blink ? 32'h14 : 32'h28, m);
   endtask : led_chk

   task automatic press(input int n);
      @(negedge i_clk);
      i_net_addr_restore_in = 1'b1;
      repeat (n) @(negedge i_clk);
      i_net_addr_restore_in = 1'b0;
   endtask : press

   initial begin
      repeat (4) @(negedge i_clk);
      i_resetn = 1'b1;
      @(negedge i_clk);
      chk(32'(o_exposure_window), 32'h1, "window idle");
      chk(o_net_addr, trig_status_pkg::NET_ADDR_DEFAULT, "addr reset");
      chk(32'(o_usb_device_mode), 32'h1, "device role");
      trig_run(1'b1, 1'b0, 1'b0, 1, 1);
      trig_run(1'b1, 1'b1, 1'b0, 0, 1);
      trig_run(1'b1, 1'b0, 1'b1, 1, 1);
      trig_run(1'b0, 1'b0, 1'b0, 0, 0);
      i_fw_upgrade = 1'b1;
      led_chk(trig_status_pkg::LED_WHITE, 1'b0, "upgrade white");
      i_fw_upgrade = 1'b0;
      i_drv_upgrade = 1'b1;
      led_chk(trig_status_pkg::LED_GREEN, 1'b1, "driver green");
      i_drv_upgrade = 1'b0;
      led_chk(trig_status_pkg::LED_GREEN, 1'b1, "enum green");
      i_usb_enumerated = 1'b1;
      led_chk(trig_status_pkg::LED_OFF, 1'b0, "enumerated off");
      // the usb variant has no restore button
      press(250);
      repeat (20) @(negedge i_clk);
      chk(32'(pur_cnt + rst_cnt), 32'h0, "usb ignores restore");
      i_variant_usb = 1'b0;
      led_chk(trig_status_pkg::LED_BLUE, 1'b1, "broadcast blue");
      i_eth_connected = 1'b1;
      led_chk(trig_status_pkg::LED_BLUE, 1'b0, "linked blue");
      i_net_addr_wdata = WADDR;
      i_net_addr_wr = 1'b1;
      @(negedge i_clk);
      i_net_addr_wr = 1'b0;
      @(negedge i_clk);
      chk(o_net_addr, WADDR, "addr write");
      // too short to reach the purple stage
      press(50);
      repeat (20) @(negedge i_clk);
      chk(32'(pur_cnt), 32'h0, "short press purple");
      chk(o_net_addr, WADDR, "short press addr");
      // released after restore but before the self reset
      press(205);
      repeat (200) @(negedge i_clk);
      chk(32'(rst_cnt), 32'h1, "restore pulse");
      chk(o_net_addr, trig_status_pkg::NET_ADDR_DEFAULT, "addr back");
      chk(32'(pur_cnt), 32'h78, "purple cycles");
      chk(32'(pur_rise), 32'h2, "purple blinks");
      chk(32'(self_cnt), 32'h1, "self reset");
      conclude();
   end

   initial begin
      repeat (60000) @(posedge i_clk);
      num_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      conclude();
   end
endmodule : tb

/* File: trig_source.sv */
`timescale 1ns/1ps
module trig_source #(
   parameter int unsigned MIN_W = 5000,
   parameter int unsigned MAX_W = 100000
) (
   // clock
   input  wire logic i_clk,
   // trigger line into the camera
   output logic      o_trig
);
   initial o_trig = 1'b0;

   // one clean edge each way: the line is already debounced here
   task automatic pulse(input int unsigned width);
      int unsigned w;
      w = (width < MIN_W) ? MIN_W : ((width > MAX_W) ? MAX_W : width);
      @(negedge i_clk);
      o_trig = 1'b1;
      repeat (w) @(negedge i_clk);
      o_trig = 1'b0;
   endtask : pulse
endmodule : trig_source

/* File: trig_status_pkg.sv */
package trig_status_pkg;

   // clock rate
   localparam int unsigned CLK_HZ         = 50_000_000;

   // timing, in the unit printed beside each name
   localparam int unsigned ADDR_HOLD_S    = 10;
   localparam int unsigned PURPLE_HOLD_S  = 5;
   localparam int unsigned PURPLE_SHOW_S  = 5;
   localparam int unsigned BLINK_HALF_MS  = 250;

   // derived cycle counts (whole seconds and milliseconds divide exactly)
   localparam int unsigned ADDR_HOLD_CYC   = CLK_HZ * ADDR_HOLD_S;
   localparam int unsigned PURPLE_HOLD_CYC = CLK_HZ * PURPLE_HOLD_S;
   localparam int unsigned PURPLE_SHOW_CYC = CLK_HZ * PURPLE_SHOW_S;
   localparam int unsigned BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_HALF_MS;

   // network address
   localparam logic [31:0] NET_ADDR_DEFAULT = 32'hC0A80165;

   // widths and reset values
   localparam int unsigned EXP_LEN_W      = 24;
   localparam int unsigned CNT_W          = 32;
   localparam logic        EXP_PIN_RESET  = 1'b1;

   // led colours as {red, green, blue}
   localparam logic [2:0] LED_OFF    = 3'h0;
   localparam logic [2:0] LED_BLUE   = 3'h1;
   localparam logic [2:0] LED_GREEN  = 3'h2;
   localparam logic [2:0] LED_PURPLE = 3'h5;
   localparam logic [2:0] LED_WHITE  = 3'h7;
   localparam int unsigned LED_R_BIT = 2;
   localparam int unsigned LED_G_BIT = 1;
   localparam int unsigned LED_B_BIT = 0;

   // blink-twice sequence: on, off, on, off
   localparam logic [1:0] BLINK_LAST_HALF = 2'h3;

   typedef enum logic [1:0] {
      EXP_IDLE = 2'b01,
      EXP_ON   = 2'b10
   } exp_state_t;

   typedef enum logic [3:0] {
      RS_IDLE   = 4'b0001,
      RS_PURPLE = 4'b0010,
      RS_BLINK  = 4'b0100,
      RS_SELF   = 4'b1000
   } rs_state_t;

endpackage : trig_status_pkg

/* File: trigger_exposure_status_logic.sv */
`timescale 1ns/1ps
module trigger_exposure_status_logic #(
   parameter int unsigned ADDR_HOLD_CYCLES  = trig_status_pkg::ADDR_HOLD_CYC,
   parameter int unsigned PURPLE_HOLD_CYCLES = trig_status_pkg::PURPLE_HOLD_CYC,
   parameter int unsigned PURPLE_SHOW_CYCLES = trig_status_pkg::PURPLE_SHOW_CYC,
   parameter int unsigned BLINK_HALF_CYCLES = trig_status_pkg::BLINK_HALF_CYC
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // pins from outside
   input  wire logic        i_acq_start,
   input  wire logic        i_net_addr_restore_in,
   // configuration, device status and address write
   input  wire logic        i_slave_mode,
   input  wire logic        i_trig_falling,
   input  wire logic        i_exp_pol_high,
   input  wire logic [23:0] i_exposure_len,
   input  wire logic        i_variant_usb,
   input  wire logic        i_usb_enumerated,
   input  wire logic        i_eth_connected,
   input  wire logic        i_fw_upgrade,
   input  wire logic        i_drv_upgrade,
   input  wire logic        i_net_addr_wr,
   input  wire logic [31:0] i_net_addr_wdata,
   // acquisition, exposure, network address, self reset and usb device role
   output logic             o_acq_start,
   output logic             o_exposing,
   output logic             o_exposure_window,
   output logic [31:0]      o_net_addr,
   output logic             o_addr_restore,
   output logic             o_self_reset,
   output logic             o_usb_device_mode,
   // status led
   output logic             o_led_red,
   output logic             o_led_green,
   output logic             o_led_blue
);
   logic [1:0] pins;
   logic       trig_now, restore_held;
   // both pins are asynchronous to i_clk
   pin_sync u_pin_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_d      ({i_net_addr_restore_in, i_acq_start}),
      .o_q      (pins)
   );
   assign trig_now     = pins[0];
   assign restore_held = pins[1];
   trig_status_pkg::exp_state_t exp_state_reg, exp_state_next;
   logic [23:0] exp_cnt_reg, exp_cnt_next;
   logic        trig_prev_reg;
   logic        acq_reg, acq_next;
   logic        exp_pin_reg, exp_pin_next;
   logic        trig_edge, trig_take;
   // synchronised copy only: sub-clock glitches are lost, source debounces
   assign trig_edge = i_trig_falling ? (!trig_now && trig_prev_reg)
                                     : (trig_now && !trig_prev_reg);
   assign trig_take = i_slave_mode && trig_edge
                      && (exp_state_reg == trig_status_pkg::EXP_IDLE);
   always_comb begin
      exp_state_next = exp_state_reg;
      exp_cnt_next   = exp_cnt_reg;
      acq_next       = trig_take;
      unique case (exp_state_reg)
         trig_status_pkg::EXP_IDLE: begin
            if (trig_take) begin
               exp_state_next = trig_status_pkg::EXP_ON;
               exp_cnt_next   = (i_exposure_len == 24'h000000)
                                ? 24'h000001 : i_exposure_len;
            end
         end
         trig_status_pkg::EXP_ON: begin
            if (exp_cnt_reg <= 24'h000001) begin
               exp_state_next = trig_status_pkg::EXP_IDLE;
               exp_cnt_next   = 24'h000000;
            end else begin
               exp_cnt_next = exp_cnt_reg - 24'h000001;
            end
         end
         default: begin
            exp_state_next = trig_status_pkg::EXP_IDLE;
            exp_cnt_next   = 24'h000000;
         end
      endcase
      exp_pin_next = !((exp_state_next == trig_status_pkg::EXP_ON)
                       ^ i_exp_pol_high);
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         exp_state_reg <= trig_status_pkg::EXP_IDLE;
         exp_cnt_reg   <= 24'h000000;
         trig_prev_reg <= 1'b0;
         acq_reg       <= 1'b0;
         exp_pin_reg   <= trig_status_pkg::EXP_PIN_RESET;
      end else begin
         exp_state_reg <= exp_state_next;
         exp_cnt_reg   <= exp_cnt_next;
         trig_prev_reg <= trig_now;
         acq_reg       <= acq_next;
         exp_pin_reg   <= exp_pin_next;
      end
   end
   assign o_acq_start       = acq_reg;
   assign o_exposing        = (exp_state_reg == trig_status_pkg::EXP_ON);
   assign o_exposure_window = exp_pin_reg;
   trig_status_pkg::rs_state_t rs_state_reg, rs_state_next;
   logic [31:0] hold_cnt_reg, hold_cnt_next;
   logic [31:0] rs_cnt_reg, rs_cnt_next;
   logic [1:0]  rs_half_reg, rs_half_next;
   logic [31:0] addr_reg, addr_next;
   logic        restore_reg, restore_next;
   logic        hold_ok;
   // the restore button exists only on the ethernet variants
   assign hold_ok = restore_held && !i_variant_usb;
   always_comb begin
      hold_cnt_next = !hold_ok ? 32'h00000000
                    : (hold_cnt_reg == ADDR_HOLD_CYCLES) ? hold_cnt_reg
                    : hold_cnt_reg + 32'h00000001;
      // fires once: the counter saturates beyond the threshold
      restore_next = hold_ok && (hold_cnt_reg == ADDR_HOLD_CYCLES - 1);
      addr_next    = restore_next ? trig_status_pkg::NET_ADDR_DEFAULT
                   : i_net_addr_wr ? i_net_addr_wdata : addr_reg;
      rs_state_next = rs_state_reg;
      rs_cnt_next   = rs_cnt_reg;
      rs_half_next  = rs_half_reg;
      unique case (rs_state_reg)
         trig_status_pkg::RS_IDLE: begin
            if (hold_ok && (hold_cnt_reg == PURPLE_HOLD_CYCLES - 1)) begin
               rs_state_next = trig_status_pkg::RS_PURPLE;
               rs_cnt_next   = 32'h00000000;
            end
         end
         trig_status_pkg::RS_PURPLE: begin
            if (rs_cnt_reg == PURPLE_SHOW_CYCLES - 1) begin
               rs_state_next = trig_status_pkg::RS_BLINK;
               rs_cnt_next   = 32'h00000000;
               rs_half_next  = 2'h0;
            end else begin
               rs_cnt_next = rs_cnt_reg + 32'h00000001;
            end
         end
         trig_status_pkg::RS_BLINK: begin
            if (rs_cnt_reg == BLINK_HALF_CYCLES - 1) begin
               rs_cnt_next = 32'h00000000;
               if (rs_half_reg == trig_status_pkg::BLINK_LAST_HALF) begin
                  rs_state_next = trig_status_pkg::RS_SELF;
               end else begin
                  rs_half_next = rs_half_reg + 2'h1;
               end
            end else begin
               rs_cnt_next = rs_cnt_reg + 32'h00000001;
            end
         end
         default: begin
            rs_state_next = trig_status_pkg::RS_IDLE;
         end
      endcase
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         hold_cnt_reg <= 32'h00000000;
         restore_reg  <= 1'b0;
         addr_reg     <= trig_status_pkg::NET_ADDR_DEFAULT;
         rs_state_reg <= trig_status_pkg::RS_IDLE;
         rs_cnt_reg   <= 32'h00000000;
         rs_half_reg  <= 2'h0;
      end else begin
         hold_cnt_reg <= hold_cnt_next;
         restore_reg  <= restore_next;
         addr_reg     <= addr_next;
         rs_state_reg <= rs_state_next;
         rs_cnt_reg   <= rs_cnt_next;
         rs_half_reg  <= rs_half_next;
      end
   end
   assign o_net_addr        = addr_reg;
   assign o_addr_restore    = restore_reg;
   assign o_self_reset      = (rs_state_reg == trig_status_pkg::RS_SELF);
   assign o_usb_device_mode = 1'b1;
   logic [31:0] blink_cnt_reg, blink_cnt_next;
   logic        blink_reg, blink_next;
   logic [2:0]  led_reg, led_next;
   always_comb begin
      blink_cnt_next = blink_cnt_reg + 32'h00000001;
      blink_next     = blink_reg;
      if (blink_cnt_reg == BLINK_HALF_CYCLES - 1) begin
         blink_cnt_next = 32'h00000000;
         blink_next     = !blink_reg;
      end
      // restore sequence outranks everything, then upgrades, then link
      if (rs_state_reg == trig_status_pkg::RS_PURPLE) begin
         led_next = trig_status_pkg::LED_PURPLE;
      end else if (rs_state_reg == trig_status_pkg::RS_BLINK) begin
         led_next = rs_half_reg[0] ? trig_status_pkg::LED_OFF
                                   : trig_status_pkg::LED_PURPLE;
      end else if (i_fw_upgrade) begin
         led_next = trig_status_pkg::LED_WHITE;
      end else if (i_drv_upgrade) begin
         led_next = blink_reg ? trig_status_pkg::LED_GREEN
                              : trig_status_pkg::LED_OFF;
      end else if (i_variant_usb) begin
         led_next = (blink_reg && !i_usb_enumerated)
                    ? trig_status_pkg::LED_GREEN
                    : trig_status_pkg::LED_OFF;
      end else if (i_eth_connected) begin
         led_next = trig_status_pkg::LED_BLUE;
      end else begin
         led_next = blink_reg ? trig_status_pkg::LED_BLUE
                              : trig_status_pkg::LED_OFF;
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         blink_cnt_reg <= 32'h00000000;
         blink_reg     <= 1'b0;
         led_reg       <= trig_status_pkg::LED_OFF;
      end else begin
         blink_cnt_reg <= blink_cnt_next;
         blink_reg     <= blink_next;
         led_reg       <= led_next;
      end
   end
   assign o_led_red   = led_reg[trig_status_pkg::LED_R_BIT];
   assign o_led_green = led_reg[trig_status_pkg::LED_G_BIT];
   assign o_led_blue  = led_reg[trig_status_pkg::LED_B_BIT];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_trig_taken;
      i_slave_mode && trig_edge
      && (exp_state_reg == trig_status_pkg::EXP_IDLE);
   endsequence
   sequence s_link_idle;
      (rs_state_reg == trig_status_pkg::RS_IDLE)
      && !i_fw_upgrade && !i_drv_upgrade;
   endsequence
   AST_NO_TRIG_MASTER: assert property (!i_slave_mode |=> !o_acq_start)
      else $error("acquisition started outside slave mode");
   AST_TRIG_STARTS: assert property (
      s_trig_taken |=> o_acq_start && o_exposing)
      else $error("accepted trigger did not start exposure");
   AST_EXP_PIN: assert property (
      o_exposure_window == !(o_exposing ^ $past(i_exp_pol_high)))
      else $error("exposure window pin disagrees with exposure state");
   AST_ONE_START: assert property (o_acq_start |=> !o_acq_start)
      else $error("two starts from one edge");
   AST_ADDR_RESTORE: assert property (
      o_addr_restore |-> $past(restore_held)
      && o_net_addr == trig_status_pkg::NET_ADDR_DEFAULT)
      else $error("address restore without hold or wrong address");
   AST_USB_BLINK: assert property (
      s_link_idle and i_variant_usb && !i_usb_enumerated
      |=> o_led_green == $past(blink_reg) && !o_led_red && !o_led_blue)
      else $error("usb enumeration blink wrong");
   AST_FW_WHITE: assert property (
      (rs_state_reg == trig_status_pkg::RS_IDLE) && i_fw_upgrade
      |=> led_reg == trig_status_pkg::LED_WHITE)
      else $error("firmware upgrade led not white");
   AST_DRV_BLINK: assert property (
      (rs_state_reg == trig_status_pkg::RS_IDLE) && !i_fw_upgrade
      && i_drv_upgrade |=> o_led_green == $past(blink_reg) && !o_led_blue)
      else $error("driver upgrade blink wrong");
   AST_ETH_BLINK: assert property (
      s_link_idle and !i_variant_usb && !i_eth_connected
      |=> o_led_blue == $past(blink_reg) && !o_led_green)
      else $error("ethernet broadcast blink wrong");
   AST_ETH_BLUE: assert property (
      s_link_idle and !i_variant_usb && i_eth_connected
      |=> led_reg == trig_status_pkg::LED_BLUE)
      else $error("connected led not steady blue");
   AST_PURPLE_ENTRY: assert property (
      (rs_state_reg == trig_status_pkg::RS_IDLE)
      ##1 (rs_state_reg == trig_status_pkg::RS_PURPLE)
      |=> (led_reg == trig_status_pkg::LED_PURPLE)[*4])
      else $error("purple phase not shown");
   AST_SELF_RESET: assert property (
      o_self_reset |-> $past(rs_state_reg) == trig_status_pkg::RS_BLINK
      && $past(rs_half_reg) == trig_status_pkg::BLINK_LAST_HALF)
      else $error("self reset before two blinks");
   AST_USB_DEVICE: assert property (o_usb_device_mode)
      else $error("usb role left device mode");
endmodule : trigger_exposure_status_logic
